/* src/otw_top.sv */
// Staged register transfer, page enable and vertical window for the display.
// Assumes Wishbone classic master, horizontal and vertical sync synchronous to clk.
//
// Operation
// - Request outside display lines transfers at next hsync falling edge.
// - Request inside a display line transfers at the hsync fall ending it.
// - Display-off lines still count as display area for transfer timing.
// - Port, sync, scan and misc mode bits act at once on write.
// - Writing 1 to control bit 2 requests a transfer; 0 requests nothing.
// - After transfer, request bit and monitor flag clear by themselves.
// - Control bit 2 reads 1 while transfer pending, 0 once done.
// - Control bit 0 enables the character display for the whole page.
// - Control bit 1 turns the vertical window on, limiting the page.
// - Two 8-bit window registers hold upper and lower limits.
// - Normal scan: limit position is value times two line periods.
// - Double scan: limit position is value times four line periods.
`timescale 1ns/1ps
`default_nettype none
module otw_top (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [otw_pkg::ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    input  wire logic              horiz_sync_in,
    input  wire logic              vert_sync_in,
    input  wire logic              in_display_line,
    output logic                   page_display_enable,
    output logic                   window_enable,
    output logic      [7:0]        window_top,
    output logic      [7:0]        window_bottom,
    output logic                   window_visible,
    output logic                   double_scan_select,
    output logic                   sync_signal_select,
    output logic      [3:0]        misc_mode,
    output logic      [3:0]        port_output_select,
    output logic                   irq
);
    import otw_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    logic bus_req;
    logic wr_en;
    logic rd_en;
    logic lane0;
    logic lane1;

    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_en   = bus_req & wb_we_i;
    assign rd_en   = bus_req & ~wb_we_i;
    assign lane0   = wb_sel_i[0];
    assign lane1   = wb_sel_i[1];

    ////////////////////////////////////////////////////////////////////////
    // Sync edge detection and scan line counter
    logic hs_fall;
    logic vs_fall;
    logic [LINE_W-1:0] line_count;
    logic [LINE_W-1:0] next_line_count;

    otw_edge u_hs_edge (
        .clk   (clk),
        .rstn  (rstn),
        .level (horiz_sync_in),
        .fall  (hs_fall)
    );

    otw_edge u_vs_edge (
        .clk   (clk),
        .rstn  (rstn),
        .level (vert_sync_in),
        .fall  (vs_fall)
    );

    always_comb begin
        next_line_count = line_count;
        if (vs_fall) begin
            next_line_count = LINE_ZERO;
        end else if (hs_fall && line_count != {LINE_W{1'b1}}) begin
            next_line_count = line_count + LINE_ONE;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            line_count <= LINE_ZERO;
        end else begin
            line_count <= next_line_count;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Staged registers, immediate registers and transfer control
    logic [7:0]        stage_ctrl;
    logic [7:0]        stage_top;
    logic [7:0]        stage_bottom;
    logic [MODE_W-1:0] mode;
    logic [IRQ_W-1:0]  irq_status;
    logic [IRQ_W-1:0]  irq_mask;
    otw_xfer_e         xfer;
    logic              deferred;
    logic [7:0]        next_stage_ctrl;
    logic [7:0]        next_stage_top;
    logic [7:0]        next_stage_bottom;
    logic [MODE_W-1:0] next_mode;
    logic [IRQ_W-1:0]  next_irq_status;
    logic [IRQ_W-1:0]  next_irq_mask;
    otw_xfer_e         next_xfer;
    logic              next_deferred;
    logic              next_page_en;
    logic              next_win_en;
    logic [7:0]        next_top;
    logic [7:0]        next_bottom;
    logic              do_xfer;
    logic              req_write;
    logic [IRQ_W-1:0]  irq_set;

    // Request write: bit 2 set in a write of the control register
    assign req_write = wr_en && lane0 && (wb_adr_i == ADDR_DISPLAY_CONTROL)
                       && wb_dat_i[BIT_XFER_REQ];

    always_comb begin
        next_xfer     = xfer;
        next_deferred = deferred;
        do_xfer       = 1'b0;
        irq_set       = RST_IRQ;
        case (xfer)
            OTW_IDLE: begin
                if (req_write) begin
                    next_xfer = OTW_WAIT;
                    // Display-off lines still flagged as display area
                    next_deferred = in_display_line;
                    if (in_display_line) begin
                        irq_set[BIT_IRQ_DEFER] = 1'b1;
                    end
                end
            end
            OTW_WAIT: begin
                if (hs_fall) begin
                    // Outside: first fall; inside: fall that ends the line
                    do_xfer   = 1'b1;
                    next_xfer = OTW_DONE;
                end
            end
            OTW_DONE: begin
                next_xfer     = OTW_IDLE;
                next_deferred = 1'b0;
                irq_set[BIT_IRQ_DONE] = 1'b1;
            end
            default: begin
                next_xfer     = OTW_IDLE;
                next_deferred = 1'b0;
            end
        endcase
    end

    always_comb begin
        next_stage_ctrl   = stage_ctrl;
        next_stage_top    = stage_top;
        next_stage_bottom = stage_bottom;
        next_mode         = mode;
        next_irq_mask     = irq_mask;
        next_irq_status   = irq_status;
        if (wr_en) begin
            case (wb_adr_i)
                ADDR_DISPLAY_CONTROL: begin
                    if (lane0) begin
                        next_stage_ctrl = wb_dat_i[7:0];
                    end
                end
                ADDR_WINDOW_UPPER: begin
                    if (lane0) begin
                        next_stage_top = wb_dat_i[7:0];
                    end
                end
                ADDR_WINDOW_LOWER: begin
                    if (lane0) begin
                        next_stage_bottom = wb_dat_i[7:0];
                    end
                end
                ADDR_MODE: begin
                    // Immediate mode bits, no staging
                    if (lane0) begin
                        next_mode[7:0] = wb_dat_i[7:0];
                    end
                    if (lane1) begin
                        next_mode[MODE_W-1:8] = wb_dat_i[MODE_W-1:8];
                    end
                end
                ADDR_IRQ_MASK: begin
                    if (lane0) begin
                        next_irq_mask = wb_dat_i[IRQ_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
        // Read clears status; a new event in the same cycle wins
        if (rd_en && wb_adr_i == ADDR_IRQ_STATUS) begin
            next_irq_status = RST_IRQ;
        end
        next_irq_status = next_irq_status | irq_set;
    end

    always_comb begin
        next_page_en = page_display_enable;
        next_win_en  = window_enable;
        next_top     = window_top;
        next_bottom  = window_bottom;
        if (do_xfer) begin
            next_page_en = stage_ctrl[BIT_PAGE_EN];
            next_win_en  = stage_ctrl[BIT_WIN_EN];
            next_top     = stage_top;
            next_bottom  = stage_bottom;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            xfer                <= OTW_IDLE;
            deferred            <= 1'b0;
            stage_ctrl          <= RST_BYTE;
            stage_top           <= RST_BYTE;
            stage_bottom        <= RST_BYTE;
            mode                <= RST_MODE;
            irq_status          <= RST_IRQ;
            irq_mask            <= RST_IRQ;
            page_display_enable <= 1'b0;
            window_enable       <= 1'b0;
            window_top          <= RST_BYTE;
            window_bottom       <= RST_BYTE;
        end else begin
            xfer                <= next_xfer;
            deferred            <= next_deferred;
            stage_ctrl          <= next_stage_ctrl;
            stage_top           <= next_stage_top;
            stage_bottom        <= next_stage_bottom;
            mode                <= next_mode;
            irq_status          <= next_irq_status;
            irq_mask            <= next_irq_mask;
            page_display_enable <= next_page_en;
            window_enable       <= next_win_en;
            window_top          <= next_top;
            window_bottom       <= next_bottom;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Window evaluation and registered outputs
    logic past_top;
    logic past_bottom;
    logic next_visible;
    logic next_irq;
    logic pending;

    otw_window u_win_top (
        .limit       (window_top),
        .double_scan (mode[BIT_DOUBLE]),
        .line_count  (line_count),
        .at_or_past  (past_top)
    );

    otw_window u_win_bottom (
        .limit       (window_bottom),
        .double_scan (mode[BIT_DOUBLE]),
        .line_count  (line_count),
        .at_or_past  (past_bottom)
    );

    assign pending = (xfer != OTW_IDLE);

    always_comb begin
        // Page visible when enabled and inside the window, if window on
        next_visible = page_display_enable
                       & (~window_enable | (past_top & ~past_bottom));
        next_irq     = |(next_irq_status & irq_mask);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            window_visible     <= 1'b0;
            double_scan_select <= 1'b0;
            sync_signal_select <= 1'b0;
            misc_mode          <= 4'h0;
            port_output_select <= 4'h0;
            irq                <= 1'b0;
        end else begin
            window_visible     <= next_visible;
            double_scan_select <= next_mode[BIT_DOUBLE];
            sync_signal_select <= next_mode[BIT_SYNC_SEL];
            misc_mode          <= next_mode[BIT_MISC_HI:BIT_MISC_LO];
            port_output_select <= next_mode[BIT_PORT_HI:BIT_PORT_LO];
            irq                <= next_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus answer: one registered ack, one cycle after the request
    logic [31:0] next_dat;

    always_comb begin
        next_dat = 32'h0000_0000;
        if (rd_en) begin
            case (wb_adr_i)
                ADDR_DISPLAY_CONTROL: begin
                    next_dat[BIT_PAGE_EN] = stage_ctrl[BIT_PAGE_EN];
                    next_dat[BIT_WIN_EN]  = stage_ctrl[BIT_WIN_EN];
                    next_dat[BIT_XFER_REQ] = pending;
                end
                ADDR_MODE: begin
                    next_dat[MODE_W-1:0] = mode;
                end
                ADDR_IRQ_STATUS: begin
                    next_dat[IRQ_W-1:0] = irq_status;
                end
                ADDR_IRQ_MASK: begin
                    next_dat[IRQ_W-1:0] = irq_mask;
                end
                ADDR_SCAN_STATUS: begin
                    next_dat[LINE_W-1:0] = line_count;
                    next_dat[BIT_SCAN_DEFER] = deferred;
                    next_dat[BIT_SCAN_PAGE]  = page_display_enable;
                    next_dat[BIT_SCAN_WIN]   = window_enable;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= next_dat;
        end
    end
endmodule
`default_nettype wire

/* src/otw_pkg.sv */
// Package for the display register transfer and window block.
// Assumes a Wishbone classic slave with 32-bit data, byte registers in bit 7:0.
package otw_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_DISPLAY_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_WINDOW_UPPER    = 8'h04;
    localparam logic [7:0] ADDR_WINDOW_LOWER    = 8'h08;
    localparam logic [7:0] ADDR_MODE            = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_STATUS      = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK        = 8'h14;
    localparam logic [7:0] ADDR_SCAN_STATUS     = 8'h18;
    localparam int         ADDR_W               = 8;

    // Display control fields
    localparam int BIT_PAGE_EN   = 0;
    localparam int BIT_WIN_EN    = 1;
    localparam int BIT_XFER_REQ  = 2;
    // Immediate mode register fields
    localparam int BIT_DOUBLE    = 0;
    localparam int BIT_SYNC_SEL  = 1;
    localparam int BIT_MISC_LO   = 2;
    localparam int BIT_MISC_HI   = 5;
    localparam int BIT_PORT_LO   = 6;
    localparam int BIT_PORT_HI   = 9;
    localparam int MODE_W        = 10;
    // Interrupt status fields
    localparam int BIT_IRQ_DONE  = 0;
    localparam int BIT_IRQ_DEFER = 1;
    localparam int IRQ_W         = 2;
    // Scan status fields above the line count
    localparam int BIT_SCAN_DEFER = 16;
    localparam int BIT_SCAN_PAGE  = 17;
    localparam int BIT_SCAN_WIN   = 18;

    localparam logic [7:0]        RST_BYTE  = 8'h00;
    localparam logic [MODE_W-1:0] RST_MODE  = 10'h000;
    localparam logic [IRQ_W-1:0]  RST_IRQ   = 2'h0;
    localparam int                LINE_W    = 11;
    localparam logic [LINE_W-1:0] LINE_ZERO = 11'h000;
    localparam logic [LINE_W-1:0] LINE_ONE  = 11'h001;
    localparam int                SHIFT_NORMAL = 1;
    localparam int                SHIFT_DOUBLE = 2;

    typedef enum logic [1:0] {
        OTW_IDLE  = 2'b00,
        OTW_WAIT  = 2'b01,
        OTW_DONE  = 2'b10
    } otw_xfer_e;
endpackage

/* src/otw_edge.sv */
// Falling edge detector for the horizontal and vertical sync inputs.
// Assumes the input is synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module otw_edge (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic level,
    output logic      fall
);
    logic prev;
    logic next_prev;

    always_comb begin
        next_prev = level;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prev <= 1'b0;
        end else begin
            prev <= next_prev;
        end
    end

    assign fall = prev & ~level;
endmodule
`default_nettype wire

/* src/otw_window.sv */
// Scaled window comparison of the line counter against a limit register.
// Assumes the line counter restarts at vertical sync.
`timescale 1ns/1ps
`default_nettype none
module otw_window (
    input  wire logic [7:0]                 limit,
    input  wire logic                       double_scan,
    input  wire logic [otw_pkg::LINE_W-1:0] line_count,
    output logic                            at_or_past
);
    import otw_pkg::*;
    logic [LINE_W-1:0] pos;

    always_comb begin
        // Two line periods per step normally, four in double scan
        if (double_scan) begin
            pos = LINE_W'({3'b000, limit} << SHIFT_DOUBLE);
        end else begin
            pos = LINE_W'({3'b000, limit} << SHIFT_NORMAL);
        end
        at_or_past = (line_count >= pos);
    end
endmodule
`default_nettype wire

/* testbench/otw_top_sva.sv */
// Checker for the display register transfer and window block.
// Assumes it is bound to otw_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module otw_top_sva (
    input wire logic              clk,
    input wire logic              rstn,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [otw_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0]        wb_sel_i,
    input wire logic [31:0]       wb_dat_i,
    input wire logic [31:0]       wb_dat_o,
    input wire logic              wb_ack_o,
    input wire logic              horiz_sync_in,
    input wire logic              page_display_enable,
    input wire logic              window_enable,
    input wire logic [7:0]        window_top,
    input wire logic [7:0]        window_bottom,
    input wire logic              window_visible,
    input wire logic              double_scan_select,
    input wire logic              irq
);
    import otw_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    ////////////////////////////////////////////////////////////////////////////////
    // Cycles since the last horizontal sync falling edge
    logic       hs_q;
    logic [2:0] since_fall;
    logic [2:0] next_since_fall;

    always_comb begin
        next_since_fall = since_fall;
        if (hs_q && !horiz_sync_in) begin
            next_since_fall = 3'h0;
        end else if (since_fall != 3'h7) begin
            next_since_fall = since_fall + 3'h1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hs_q       <= 1'b0;
            since_fall <= 3'h7;
        end else begin
            hs_q       <= horiz_sync_in;
            since_fall <= next_since_fall;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    AST_ACK_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    AST_DAT_IDLE: assert property (!(wb_ack_o && !wb_we_i) |-> wb_dat_o == 32'h0000_0000)
        else $error("read data nonzero outside read ack");
    AST_WO_READ: assert property (wb_ack_o && !wb_we_i && (wb_adr_i == ADDR_WINDOW_UPPER ||
        wb_adr_i == ADDR_WINDOW_LOWER) |-> wb_dat_o == 32'h0000_0000)
        else $error("window limit read not zero");
    AST_XFER_SYNC: assert property (($changed(page_display_enable) ||
        $changed(window_enable) || $changed(window_top) || $changed(window_bottom))
        |-> since_fall <= 3'h3)
        else $error("active value changed away from sync fall");
    AST_MODE_NOW: assert property (wb_ack_o && wb_we_i && wb_adr_i == ADDR_MODE &&
        wb_sel_i[0] |-> ##2 double_scan_select == $past(wb_dat_i[BIT_DOUBLE], 2))
        else $error("scan mode not applied at once");
    AST_VIS_OFF: assert property (!page_display_enable |=> !window_visible)
        else $error("visible while page disabled");
    AST_VIS_NOWIN: assert property (page_display_enable && !window_enable |=> window_visible)
        else $error("not visible with window off");

    C_XFER: cover property ($rose(page_display_enable));
    C_WIN:  cover property ($rose(window_visible) && window_enable);
    C_IRQ:  cover property ($rose(irq));
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the display register transfer and window block.
// Assumes otw_pkg, otw_top and otw_top_sva are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
    $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module testbench;
    import otw_pkg::*;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic        hs = 1'b0;
    logic        vs = 1'b0;
    logic        idl = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0000_0000;
    wire logic [31:0] dat_o;
    wire logic        ack, page, win, vis, dbl, ssel, irq;
    wire logic [7:0]  top, bot;
    wire logic [3:0]  misc, port;
    int          miscompares = 0;
    int          n_checks = 0;

    always #50 clk = ~clk;

    otw_top DUT (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .horiz_sync_in(hs), .vert_sync_in(vs), .in_display_line(idl),
        .page_display_enable(page), .window_enable(win), .window_top(top),
        .window_bottom(bot), .window_visible(vis), .double_scan_select(dbl),
        .sync_signal_select(ssel), .misc_mode(misc), .port_output_select(port), .irq(irq));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w,
                       output logic [31:0] q);
        int n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) miscompares++;
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        @(negedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, d, 1'b1, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(a, 32'h0000_0000, 1'b0, q);
        `CHK(q, e)
    endtask

    // One sync pulse ending in a falling edge
    task automatic hpulse;
        @(posedge clk);
        hs <= 1'b1;
        repeat (2) @(posedge clk);
        hs <= 1'b0;
        repeat (5) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic stop_test;
        if (miscompares == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        rd(ADDR_DISPLAY_CONTROL, 32'h0000_0000);
        wr(8'h20, 32'h0000_00FF);
        rd(8'h20, 32'h0000_0000);
        wr(ADDR_MODE, 32'h0000_03FF);
        `CHK({port, misc, ssel, dbl}, 10'h3FF)
        wr(ADDR_MODE, 32'h0000_0000);
        `CHK({port, misc, ssel, dbl}, 10'h000)
        wr(ADDR_IRQ_MASK, 32'h0000_0001);
        rd(ADDR_IRQ_MASK, 32'h0000_0001);
        wr(ADDR_WINDOW_UPPER, 32'h0000_0001);
        wr(ADDR_WINDOW_LOWER, 32'h0000_0003);
        rd(ADDR_WINDOW_LOWER, 32'h0000_0000);
        // Request outside a display line
        wr(ADDR_DISPLAY_CONTROL, 32'h0000_0005);
        repeat (3) @(posedge clk);
        rd(ADDR_DISPLAY_CONTROL, 32'h0000_0005);
        `CHK(page, 1'b0)
        hpulse;
        `CHK({page, win, irq}, 3'b101)
        rd(ADDR_DISPLAY_CONTROL, 32'h0000_0001);
        rd(ADDR_IRQ_STATUS, 32'h0000_0001);
        repeat (2) @(negedge clk);
        `CHK(irq, 1'b0)
        // Request inside a display line waits for its end
        @(posedge clk) idl <= 1'b1;
        wr(ADDR_DISPLAY_CONTROL, 32'h0000_0007);
        repeat (10) @(negedge clk);
        `CHK(win, 1'b0)
        hpulse;
        `CHK({win, top, bot}, 17'h1_0103)
        rd(ADDR_IRQ_STATUS, 32'h0000_0003);
        @(posedge clk) idl <= 1'b0;
        // Staged write without request moves nothing; bit 2 never written 0
        wr(ADDR_WINDOW_UPPER, 32'h0000_0005);
        hpulse;
        `CHK({page, top}, 9'h101)
        rd(ADDR_DISPLAY_CONTROL, 32'h0000_0003);
        wr(ADDR_WINDOW_UPPER, 32'h0000_0001);
        // Masked completion keeps irq low
        wr(ADDR_IRQ_MASK, 32'h0000_0000);
        wr(ADDR_DISPLAY_CONTROL, 32'h0000_0007);
        hpulse;
        `CHK({page, irq}, 2'b10)
        rd(ADDR_IRQ_STATUS, 32'h0000_0001);
        // Window limits scaled by two or four lines
        for (int m = 0; m < 2; m++) begin
            wr(ADDR_MODE, m);
            @(posedge clk) vs <= 1'b1;
            repeat (2) @(posedge clk);
            vs <= 1'b0;
            repeat (4) @(negedge clk);
            for (int l = 0; l < 14; l++) begin
                rd(ADDR_SCAN_STATUS, 32'h0006_0000 | l);
                `CHK(vis, (l >= 2 * (m + 1) && l < 6 * (m + 1)))
                hpulse;
            end
        end
        // Page enable cleared by a last transfer before the test stops
        wr(ADDR_DISPLAY_CONTROL, 32'h0000_0004);
        hpulse;
        `CHK(page, 1'b0)
        stop_test;
    end

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        stop_test;
    end
endmodule

bind otw_top otw_top_sva u_sva (.clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .horiz_sync_in(horiz_sync_in), .page_display_enable(page_display_enable),
    .window_enable(window_enable), .window_top(window_top), .window_bottom(window_bottom),
    .window_visible(window_visible), .double_scan_select(double_scan_select), .irq(irq));
`default_nettype wire
